//--- hw/spdc_pkg.sv
// Package for the switch port device control register bank.
// Assumes an APB master on the same clock as the bank.
package spdc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] SPDC_OFF_DEV_CTRL = 8'hC8;
  localparam logic [7:0] SPDC_OFF_ERR_EVT = 8'hCC;
  localparam logic [15:0] SPDC_CTRL_RESET = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SPDC_BIT_CORR_EN = 0;
  localparam int SPDC_BIT_NONFATAL_EN = 1;
  localparam int SPDC_BIT_FATAL_EN = 2;
  localparam int SPDC_BIT_UNSUP_EN = 3;
  localparam int SPDC_BIT_RELAX_ORD = 4;
  localparam int SPDC_PAYLOAD_LSB = 5;
  localparam int SPDC_PAYLOAD_MSB = 7;
  localparam int SPDC_BIT_EXT_TAG = 8;
  localparam int SPDC_BIT_PHANTOM = 9;
  localparam int SPDC_BIT_AUX_PWR = 10;
  localparam int SPDC_BIT_NO_SNOOP = 11;
  localparam int SPDC_RDREQ_LSB = 12;
  localparam int SPDC_RDREQ_MSB = 14;
  localparam int SPDC_BIT_RSVD = 15;

  // ****************************************************************
  // Payload capability codes
  // ****************************************************************
  localparam logic [2:0] SPDC_PAYLOAD_RESET = 3'h0;
  localparam logic [2:0] SPDC_CAP_256 = 3'h1;
  localparam logic [2:0] SPDC_CAP_512 = 3'h2;
  localparam logic [2:0] SPDC_RDREQ_FIXED = 3'h0;

  // Error event group; order is correctable, non-fatal, fatal, unsupported.
  typedef struct packed {
    logic unsup;
    logic fatal;
    logic nonfatal;
    logic corr;
  } spdc_err_type;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } spdc_apb_req_type;

endpackage : spdc_pkg

//--- hw/spdc_regs.sv
// Device control register bank of one switch port, reached over APB.
// Assumes the error detectors and the payload strap come from outside the clock domain.
//
// Notes on behaviour
// RULE_01: bit 0 correctable error report enable, reset 0
// RULE_02: bit 1 non-fatal error report enable, reset 0
// RULE_03: bit 2 fatal error report enable, reset 0
// RULE_04: bit 3 unsupported request report enable
// RULE_05: bit 4 reads zero, writes ignored
// RULE_06: bits 7:5 writable payload limit, reset 000b
// RULE_07: oversize payload write stores supported capability
// RULE_08: bits 8 and 9 always read zero
// RULE_09: bit 10 sticky aux power enable, power-on reset
// RULE_10: bit 11 reads zero, writes ignored
// RULE_11: bits 14:12 hardwired to 000b
// RULE_12: reserved bit 15 reads zero, writes ignored
// RULE_13: capability 001b strap low, 010b strap high
// RULE_14: error detected flags set regardless of enables
// RULE_15: writes update only the read-write fields
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module spdc_regs
  import spdc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_payload_512_strap,
  input wire spdc_err_type i_err_detect,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output spdc_err_type o_err_report_en,
  output logic [2:0] o_payload_limit,
  output logic o_aux_power_en,
  output spdc_err_type o_err_detected
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic strap_meta_reg;
  logic strap_sync_reg;
  spdc_err_type err_meta_reg;
  spdc_err_type err_sync_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      err_meta_reg <= '0;
      err_sync_reg <= '0;
    end else begin
      strap_meta_reg <= i_payload_512_strap;
      strap_sync_reg <= strap_meta_reg;
      err_meta_reg <= i_err_detect;
      err_sync_reg <= err_meta_reg;
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire access = i_psel && i_penable;
  wire hit_ctrl = (i_paddr == SPDC_OFF_DEV_CTRL);
  wire hit_evt = (i_paddr == SPDC_OFF_ERR_EVT);
  wire wr_ctrl = access && i_pwrite && hit_ctrl;
  wire wr_evt = access && i_pwrite && hit_evt;
  wire lo_lane = i_pstrb[0];
  wire hi_lane = i_pstrb[1];

  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit_ctrl && !hit_evt;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  logic [3:0] en_reg;
  logic [3:0] en_next;
  logic [2:0] payload_reg;
  logic [2:0] payload_next;
  logic aux_reg;
  logic aux_next;

  // The capability follows the strap live, as the capability register does.
  wire [2:0] cap_code = strap_sync_reg ? SPDC_CAP_512 : SPDC_CAP_256; // RULE_13
  wire [2:0] wr_payload = i_pwdata[SPDC_PAYLOAD_MSB:SPDC_PAYLOAD_LSB];
  wire [2:0] clamped = (wr_payload > cap_code) ? cap_code : wr_payload; // RULE_07

  assign en_next = (wr_ctrl && lo_lane) ? i_pwdata[SPDC_BIT_UNSUP_EN:SPDC_BIT_CORR_EN]
                                        : en_reg; // RULE_15
  assign payload_next = (wr_ctrl && lo_lane) ? clamped : payload_reg; // RULE_06
  assign aux_next = (wr_ctrl && hi_lane) ? i_pwdata[SPDC_BIT_AUX_PWR] : aux_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_reg <= SPDC_CTRL_RESET[SPDC_BIT_UNSUP_EN:SPDC_BIT_CORR_EN]; // RULE_01 RULE_02 RULE_03 RULE_04
      payload_reg <= SPDC_PAYLOAD_RESET; // RULE_06
    end else begin
      en_reg <= en_next; // RULE_01 RULE_02 RULE_03 RULE_04
      payload_reg <= payload_next;
    end
  end

  // Sticky bit sits on the power-on reset only, so a port reset keeps it.
  always_ff @(posedge i_clk_sys or negedge i_por_n) begin
    if (!i_por_n) begin
      aux_reg <= SPDC_CTRL_RESET[SPDC_BIT_AUX_PWR]; // RULE_09
    end else begin
      aux_reg <= aux_next; // RULE_09
    end
  end

  // ****************************************************************
  // Error detected flags
  // ****************************************************************
  spdc_err_type det_reg;
  spdc_err_type det_next;
  wire [3:0] clr_mask = (wr_evt && lo_lane) ? i_pwdata[3:0] : 4'h0;

  // A new event outranks a same-cycle write-one-to-clear.
  assign det_next = (det_reg & ~clr_mask) | err_sync_reg; // RULE_14

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_next; // RULE_14
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [15:0] ctrl_view;
  always_comb begin
    ctrl_view = 16'h0000; // RULE_05 RULE_08 RULE_10 RULE_12
    ctrl_view[SPDC_BIT_UNSUP_EN:SPDC_BIT_CORR_EN] = en_reg;
    ctrl_view[SPDC_PAYLOAD_MSB:SPDC_PAYLOAD_LSB] = payload_reg;
    ctrl_view[SPDC_BIT_AUX_PWR] = aux_reg;
    ctrl_view[SPDC_RDREQ_MSB:SPDC_RDREQ_LSB] = SPDC_RDREQ_FIXED; // RULE_11
  end

  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_view} :
                       hit_evt ? {28'h0000000, det_reg} : 32'h00000000;

  logic [31:0] rdata_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      rdata_reg <= rd_mux;
    end
  end

  assign o_prdata = rdata_reg;
  assign o_err_report_en = en_reg;
  assign o_payload_limit = payload_reg;
  assign o_aux_power_en = aux_reg;
  assign o_err_detected = det_reg;

endmodule : spdc_regs

//--- test/spdc_regs_chk.sv
// Assertions for the port device control bank, bound to spdc_regs.
// Assumes one clock domain and zero-wait APB.
`timescale 1ns/1ps
module spdc_regs_chk
  import spdc_pkg::*;
(
  input wire logic i_clk_sys, i_rst_n, i_por_n, i_psel, i_penable, i_pwrite,
  input wire logic i_payload_512_strap, o_pslverr, o_aux_power_en,
  input wire logic [7:0] i_paddr,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] i_pwdata, o_prdata,
  input wire logic [2:0] o_payload_limit,
  input wire spdc_err_type i_err_detect, o_err_report_en, o_err_detected
);
  wire acc = i_psel && i_penable;
  wire ctl = acc && i_pwrite && i_paddr == SPDC_OFF_DEV_CTRL;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_en_write: assert property (ctl && i_pstrb[0] |=>
    o_err_report_en == $past(i_pwdata[3:0])) else $error("enables not written");
  a_limit_keep: assert property (ctl && i_pstrb[0] && i_pwdata[7:5] < 3'h2 |=>
    o_payload_limit == $past(i_pwdata[7:5])) else $error("limit not written");
  a_limit_clamp: assert property (ctl && i_pstrb[0] && i_pwdata[7:5] > 3'h2 |=>
    o_payload_limit == {1'b0, $past(i_payload_512_strap, 3), !$past(i_payload_512_strap, 3)})
    else $error("limit not clamped");
  a_aux_write: assert property (ctl && i_pstrb[1] |=>
    o_aux_power_en == $past(i_pwdata[10])) else $error("aux not written");
  a_aux_sticky: assert property (disable iff (!i_por_n) !i_rst_n |=>
    $stable(o_aux_power_en)) else $error("aux lost in port reset");
  a_reset_clear: assert property ($rose(i_rst_n) |->
    o_err_report_en == 4'h0 && o_payload_limit == 3'h0) else $error("reset values");
  a_ro_zero: assert property (acc && !i_pwrite && i_paddr == SPDC_OFF_DEV_CTRL |->
    (o_prdata & 32'hFFFF_FB10) == 32'h0) else $error("fixed bits not zero");
  a_err_logged: assert property (i_err_detect != 4'h0 |-> ##3
    (o_err_detected & $past(i_err_detect, 3)) == $past(i_err_detect, 3)) else $error("no flag");
  a_err_clear: assert property (acc && i_pwrite && i_paddr == SPDC_OFF_ERR_EVT &&
    i_pstrb[0] && $past(i_err_detect, 2) == 4'h0 |=>
    (o_err_detected & $past(i_pwdata[3:0])) == 4'h0) else $error("flag not cleared");
  a_bad_addr: assert property (acc && i_paddr != SPDC_OFF_DEV_CTRL &&
    i_paddr != SPDC_OFF_ERR_EVT |-> o_pslverr) else $error("no slave error");
endmodule : spdc_regs_chk
bind spdc_regs spdc_regs_chk u_chk (.i_clk_sys, .i_rst_n, .i_por_n, .i_psel, .i_penable,
  .i_pwrite, .i_payload_512_strap, .o_pslverr, .o_aux_power_en, .i_paddr, .i_pstrb,
  .i_pwdata, .o_prdata, .o_payload_limit, .i_err_detect, .o_err_report_en, .o_err_detected);

//--- test/spdc_regs_tb_top.sv
// Testbench for the port device control bank.
// Assumes the checker is bound in beside the design.
`timescale 1ns/1ps
module spdc_regs_tb_top
  import spdc_pkg::*;
;
  logic i_clk_sys = 1'h0, i_rst_n = 1'h0, i_por_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
  logic i_pwrite = 1'h0, i_payload_512_strap = 1'h0, o_pready, o_pslverr, o_aux_power_en, serr;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [3:0] i_pstrb = 4'hF;
  logic [2:0] o_payload_limit, cap;
  spdc_err_type i_err_detect = 4'h0, o_err_report_en, o_err_detected;
  int error_cnt = 0, compares = 0;
  spdc_regs u_spdc_regs (.*);
  always #12.5 i_clk_sys = ~i_clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'h1;
    do @(posedge i_clk_sys); while (o_pready !== 1'h1);
    rd = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask : xfer
  task automatic test_done();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    i_por_n <= 1'h1;
    xfer(1'h0, SPDC_OFF_DEV_CTRL, 32'h0);
    check(rd, 32'h0);
    xfer(1'h1, SPDC_OFF_DEV_CTRL, 32'hFFFF_FFFF);
    xfer(1'h0, SPDC_OFF_DEV_CTRL, 32'h0);
    check(rd, 32'h0000_042F);
    $display("fixed bits done");
    for (int s = 0; s < 2; s++) begin
      i_payload_512_strap <= s[0];
      cap = s[0] ? SPDC_CAP_512 : SPDC_CAP_256;
      repeat (3) @(posedge i_clk_sys);
      for (int v = 0; v < 8; v++) begin
        xfer(1'h1, SPDC_OFF_DEV_CTRL, 32'(v << 5));
        xfer(1'h0, SPDC_OFF_DEV_CTRL, 32'h0);
        check(32'(rd[7:5]), 32'(v > cap ? cap : v));
        check(32'(o_payload_limit), 32'(v > cap ? cap : v));
      end
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, SPDC_OFF_DEV_CTRL, 32'(1 << i));
      @(negedge i_clk_sys);
      check(32'(o_err_report_en), 32'(1 << i));
    end
    $display("fields done");
    xfer(1'h1, SPDC_OFF_DEV_CTRL, 32'h0000_0401);
    i_rst_n <= 1'h0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    @(negedge i_clk_sys);
    check(32'({o_aux_power_en, o_err_report_en}), 32'h10);
    @(posedge i_clk_sys);
    i_por_n <= 1'h0;
    i_rst_n <= 1'h0;
    @(negedge i_clk_sys);
    check(32'(o_aux_power_en), 32'h0);
    @(posedge i_clk_sys);
    i_por_n <= 1'h1;
    i_rst_n <= 1'h1;
    $display("sticky done");
    @(posedge i_clk_sys);
    i_err_detect <= 4'hF;
    @(posedge i_clk_sys);
    i_err_detect <= 4'h0;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check(32'(o_err_detected), 32'hF);
    xfer(1'h0, SPDC_OFF_ERR_EVT, 32'h0);
    check(rd, 32'hF);
    xfer(1'h1, SPDC_OFF_ERR_EVT, 32'h0000_0005);
    xfer(1'h0, SPDC_OFF_ERR_EVT, 32'h0);
    check(rd, 32'hA);
    check(32'(o_err_detected), 32'hA);
    xfer(1'h1, 8'h10, 32'hFFFF_FFFF);
    check(32'(serr), 32'h1);
    xfer(1'h0, SPDC_OFF_DEV_CTRL, 32'h0);
    check(rd, 32'h0);
    $display("errors done");
    test_done();
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule : spdc_regs_tb_top
